// [hw/xtb_regs.sv]
// Crossover, trim and bass parameter registers behind a two-wire
// serial slave, with decoded parameters held for the audio datapath.
// Assumes scl and sda arrive asynchronously from pins and that
// sample_tick is a one-cycle pulse on clk at each sample boundary.
`timescale 1ns/1ps
module xtb_regs
    import xtb_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = XTB_DEV_ADDR
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial control port pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Datapath timing
    input wire logic sample_tick,
    // Decoded parameters for the datapath
    output logic [9:0] tweeter_hp_hz,
    output logic signed [5:0] tweeter_trim_db,
    output logic signed [5:0] woofer_trim_db,
    output logic [4:0] bass_boost_db,
    output logic [8:0] bass_center_hz
);
    logic scl_s1, scl_s2, scl_d;
    logic sda_s1, sda_s2, sda_d;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    xtb_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic rd_mode, nack, tx_low;
    logic [1:0] phase;
    logic [15:0] ptr;
    logic [7:0] data_hi;
    logic wr_stb;
    logic [15:0] wr_addr, wr_data;
    logic [15:0] reg_xover, reg_trim, reg_bass;
    logic [15:0] rd_word;

    function automatic logic [15:0] read_reg(input logic [15:0] a,
        input logic [15:0] x, input logic [15:0] t, input logic [15:0] b);
        unique case (a)
            XTB_OFS_XOVER: read_reg = x;
            XTB_OFS_TRIM: read_reg = t;
            XTB_OFS_BASS: read_reg = b;
            default: read_reg = 16'h0000;
        endcase
    endfunction

    // Trim code to signed dB; codes above 0x1C extrapolate, and codes above 0x2E wrap
    function automatic logic signed [5:0] trim_db(input logic [5:0] c);
        trim_db = XTB_TRIM_TOP_DB - c;
    endfunction

    // Pins pass two flops; edges are found only on the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
        end
    end

    assign scl_rise = scl_s2 & ~scl_d;
    assign scl_fall = ~scl_s2 & scl_d;
    assign bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
    assign bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;
    assign sda_out = 1'b0;
    assign sda_oe = tx_low;
    // Word at the pointer, ready for whichever byte is sent next
    assign rd_word = read_reg(ptr, reg_xover, reg_trim, reg_bass);

    // Serial slave: byte engine, address pointer and write strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= XTB_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            rd_mode <= 1'b0;
            nack <= 1'b0;
            tx_low <= 1'b0;
            phase <= 2'h0;
            ptr <= 16'h0000;
            data_hi <= 8'h00;
            wr_stb <= 1'b0;
            wr_addr <= 16'h0000;
            wr_data <= 16'h0000;
        end else begin
            wr_stb <= 1'b0;
            if (bus_start) begin
                // Repeated start keeps the pointer for a following read
                state <= XTB_ADDR;
                bit_cnt <= 4'h0;
                tx_low <= 1'b0;
                phase <= 2'h0;
            end else if (bus_stop) begin
                state <= XTB_IDLE;
                tx_low <= 1'b0;
            end else begin
                unique case (state)
                    XTB_IDLE: ;
                    XTB_ADDR, XTB_RX: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda_s2};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == XTB_BITS) begin
                            bit_cnt <= 4'h0;
                            if (state == XTB_ADDR) begin
                                if (shift[7:1] == DEV_ADDR) begin
                                    state <= XTB_ADDR_ACK;
                                    rd_mode <= shift[0];
                                    tx_low <= 1'b1;
                                end else begin
                                    state <= XTB_IDLE;
                                end
                            end else begin
                                state <= XTB_RX_ACK;
                                tx_low <= 1'b1;
                                unique case (phase)
                                    2'h0: ptr[15:8] <= shift;
                                    2'h1: ptr[7:0] <= shift;
                                    2'h2: data_hi <= shift;
                                    2'h3: begin
                                        wr_stb <= 1'b1;
                                        wr_addr <= ptr;
                                        wr_data <= {data_hi, shift};
                                        ptr <= ptr + 16'h0001;
                                    end
                                endcase
                                phase <= (phase == 2'h3) ? 2'h2
                                    : phase + 2'h1;
                            end
                        end
                    end
                    XTB_ADDR_ACK: begin
                        if (scl_fall) begin
                            if (rd_mode) begin
                                state <= XTB_TX;
                                phase <= 2'h0;
                                shift <= rd_word[15:8];
                                tx_low <= ~rd_word[15];
                            end else begin
                                state <= XTB_RX;
                                tx_low <= 1'b0;
                            end
                        end
                    end
                    XTB_RX_ACK: begin
                        if (scl_fall) begin
                            state <= XTB_RX;
                            tx_low <= 1'b0;
                        end
                    end
                    XTB_TX: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt == XTB_BITS) begin
                                state <= XTB_TX_ACK;
                                bit_cnt <= 4'h0;
                                tx_low <= 1'b0;
                            end else begin
                                shift <= {shift[6:0], 1'b0};
                                tx_low <= ~shift[6];
                            end
                        end
                    end
                    XTB_TX_ACK: begin
                        if (scl_rise) begin
                            nack <= sda_s2;
                        end else if (scl_fall) begin
                            if (nack) begin
                                state <= XTB_IDLE;
                            end else if (phase == 2'h0) begin
                                // Low byte of the same word
                                state <= XTB_TX;
                                phase <= 2'h1;
                                shift <= rd_word[7:0];
                                tx_low <= ~rd_word[7];
                                ptr <= ptr + 16'h0001;
                            end else begin
                                state <= XTB_TX;
                                phase <= 2'h0;
                                shift <= rd_word[15:8];
                                tx_low <= ~rd_word[15];
                            end
                        end
                    end
                    default: state <= XTB_IDLE;
                endcase
            end
        end
    end

    // Register file; only a complete 16-bit word updates a register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_xover <= XTB_RST_XOVER;
            reg_trim <= XTB_RST_TRIM;
            reg_bass <= XTB_RST_BASS;
        end else if (wr_stb) begin
            if (wr_addr == XTB_OFS_XOVER) begin
                reg_xover <= wr_data & XTB_MASK_XOVER;
            end
            if (wr_addr == XTB_OFS_TRIM) begin
                reg_trim <= wr_data & XTB_MASK_TRIM;
            end
            if (wr_addr == XTB_OFS_BASS) begin
                reg_bass <= wr_data & XTB_MASK_BASS;
            end
        end
    end

    // Datapath copies change only on a sample tick, never mid-sample
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tweeter_hp_hz <= XTB_RST_HP_HZ;
            tweeter_trim_db <= XTB_RST_TRIM_DB;
            woofer_trim_db <= XTB_RST_TRIM_DB;
            bass_boost_db <= XTB_RST_BOOST_DB;
            bass_center_hz <= XTB_RST_CENTER_HZ;
        end else if (sample_tick) begin
            tweeter_hp_hz <= XTB_HP_BASE_HZ + XTB_HP_STEP_HZ
                * {4'h0, reg_xover[XTB_HP_LSB +: 6]};
            tweeter_trim_db <= trim_db(reg_trim[XTB_TWT_LSB +: 6]);
            woofer_trim_db <= trim_db(reg_trim[XTB_WOOF_LSB +: 6]);
            bass_boost_db <= reg_bass[XTB_BOOST_LSB +: 5];
            bass_center_hz <= XTB_BF_STEP_HZ
                * ({5'h00, reg_bass[XTB_BFREQ_LSB +: 4]} + 9'h001);
        end
    end
endmodule

// [hw/xtb_pkg.sv]
// Constants for the crossover, trim and bass parameter registers.
// Assumes a host on the two-wire serial control port with 16-bit
// register addresses and 16-bit data words, high byte first.
package xtb_pkg;
    localparam logic [15:0] XTB_OFS_XOVER = 16'h0109;
    localparam logic [15:0] XTB_OFS_TRIM = 16'h010A;
    localparam logic [15:0] XTB_OFS_BASS = 16'h010B;

    localparam logic [15:0] XTB_RST_XOVER = 16'h0505;
    localparam logic [15:0] XTB_RST_TRIM = 16'h0E0E;
    localparam logic [15:0] XTB_RST_BASS = 16'h0062;

    // Decoded datapath values that match the register reset codes
    localparam logic [9:0] XTB_RST_HP_HZ = 10'h064;
    localparam logic [5:0] XTB_RST_TRIM_DB = 6'h00;
    localparam logic [4:0] XTB_RST_BOOST_DB = 5'h06;
    localparam logic [8:0] XTB_RST_CENTER_HZ = 9'h03C;

    // Reserved bits are stored as zero whatever the host sends
    localparam logic [15:0] XTB_MASK_XOVER = 16'h3F3F;
    localparam logic [15:0] XTB_MASK_TRIM = 16'h3F3F;
    localparam logic [15:0] XTB_MASK_BASS = 16'h01FF;

    localparam int XTB_HP_LSB = 0;
    localparam int XTB_TWT_LSB = 8;
    localparam int XTB_WOOF_LSB = 0;
    localparam int XTB_BOOST_LSB = 4;
    localparam int XTB_BFREQ_LSB = 0;

    localparam logic [9:0] XTB_HP_BASE_HZ = 10'h032;
    localparam logic [9:0] XTB_HP_STEP_HZ = 10'h00A;
    localparam logic [5:0] XTB_TRIM_TOP_DB = 6'h0E;
    localparam logic [8:0] XTB_BF_STEP_HZ = 9'h014;

    localparam logic [6:0] XTB_DEV_ADDR = 7'h34;
    localparam logic [3:0] XTB_BITS = 4'h8;

    typedef enum logic [2:0] {
        XTB_IDLE, XTB_ADDR, XTB_ADDR_ACK, XTB_RX, XTB_RX_ACK,
        XTB_TX, XTB_TX_ACK
    } xtb_state_t;
endpackage

// [verif/xtb_regs_properties.sv]
// Port checker for the crossover, trim and bass registers.
// Assumes it is bound to xtb_regs and sees only its ports.
`timescale 1ns/1ps
module xtb_regs_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial pins
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Datapath side
    input wire logic sample_tick,
    input wire logic [9:0] tweeter_hp_hz,
    input wire logic signed [5:0] tweeter_trim_db,
    input wire logic signed [5:0] woofer_trim_db,
    input wire logic [4:0] bass_boost_db,
    input wire logic [8:0] bass_center_hz
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence scl_settled;
        scl_in [*4];
    endsequence
    a_sda_low: assert property (sda_oe |-> !sda_out)
        else $error("data pin driven high");
    a_rst_hp: assert property ($fell(rst) |-> tweeter_hp_hz == 10'h064)
        else $error("cutoff not 100 Hz after reset");
    a_rst_trim: assert property ($fell(rst) |-> {tweeter_trim_db,
        woofer_trim_db} == 12'h000) else $error("trims not 0 dB");
    a_rst_bass: assert property ($fell(rst) |-> {bass_boost_db,
        bass_center_hz} == 14'h0C3C) else $error("bass reset wrong");
    a_hp_grid: assert property (tweeter_hp_hz >= 10'h032 &&
        tweeter_hp_hz <= 10'h2A8 && (tweeter_hp_hz - 10'h032) % 10'h00A
        == 10'h000) else $error("cutoff off its 10 Hz grid");
    a_center_grid: assert property (bass_center_hz % 9'h014 == 9'h000 &&
        bass_center_hz != 9'h000 && bass_center_hz <= 9'h140)
        else $error("centre off its 20 Hz grid");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data pin changed while clock high");
    a_oe_steady: assert property (scl_settled |-> $stable(sda_oe))
        else $error("data pin unstable in clock high");
    a_hold_xover: assert property (!$past(sample_tick) |->
        $stable({tweeter_hp_hz, tweeter_trim_db, woofer_trim_db}))
        else $error("tweeter parameters moved between ticks");
    a_hold_bass: assert property (!$past(sample_tick) |->
        $stable({bass_boost_db, bass_center_hz}))
        else $error("bass parameters moved between ticks");
endmodule
bind xtb_regs xtb_regs_properties u_props (.clk(clk), .rst(rst),
    .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .sample_tick(sample_tick), .tweeter_hp_hz(tweeter_hp_hz),
    .tweeter_trim_db(tweeter_trim_db), .woofer_trim_db(woofer_trim_db),
    .bass_boost_db(bass_boost_db), .bass_center_hz(bass_center_hz));

// [verif/xtb_host.sv]
// Host model for the two-wire serial control port.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
module xtb_host (
    // Clock and resolved data wire
    input wire logic clk,
    input wire logic sda,
    // Line drives, high means released
    output logic scl,
    output logic sda_rel
);
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    // Lines change 1 ns after an edge so no race with the design
    task automatic hc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Clock phases of 8 cycles outlast the 2-flop synchroniser
    task automatic bit_io(input logic b, output logic r);
        sda_rel = b;
        hc(6);
        scl = 1'b1;
        hc(4);
        r = sda;
        hc(4);
        scl = 1'b0;
        hc(2);
    endtask
    task automatic start();
        sda_rel = 1'b1;
        hc(6);
        scl = 1'b1;
        hc(6);
        sda_rel = 1'b0;
        hc(6);
        scl = 1'b0;
        hc(2);
    endtask
    task automatic stop();
        sda_rel = 1'b0;
        hc(6);
        scl = 1'b1;
        hc(6);
        sda_rel = 1'b1;
        hc(6);
    endtask
    // Eight bits most significant first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic a_in,
        output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(a_in, a);
    endtask
endmodule

// [verif/tb.sv]
// Self-checking bench for the crossover, trim and bass registers.
// Assumes xtb_host drives the serial port; the bench drives the tick.
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
    n_mismatch++; $display("[FAIL] %0t got %h exp %h", $time, a, e); \
    end end
module tb;
    import xtb_pkg::*;
    logic clk, rst, sample_tick, sda_out, sda_oe, scl, sda_rel;
    logic [9:0] hp;
    logic signed [5:0] tw, wf;
    logic [4:0] boost;
    logic [8:0] center;
    wire sda;
    int n_mismatch = 0, comparisons = 0, cycles = 0;
    assign sda = sda_oe ? sda_out : sda_rel;
    xtb_regs uut (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .sample_tick(sample_tick),
        .tweeter_hp_hz(hp), .tweeter_trim_db(tw), .woofer_trim_db(wf),
        .bass_boost_db(boost), .bass_center_hz(center));
    xtb_host host (.clk(clk), .sda(sda), .scl(scl), .sda_rel(sda_rel));
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic addr(input logic [15:0] ra);
        logic [7:0] q;
        logic a;
        host.start();
        host.xfer({XTB_DEV_ADDR, 1'b0}, 1'b1, q, a);
        host.xfer(ra[15:8], 1'b1, q, a);
        host.xfer(ra[7:0], 1'b1, q, a);
        `CHK(a, 1'b0)
    endtask
    task automatic wr(input logic [15:0] ra, input logic [31:0] w,
        input int n);
        logic [7:0] q;
        logic a;
        addr(ra);
        for (int k = 0; k < 2 * n; k++) begin
            host.xfer(w[31 - 8 * k -: 8], 1'b1, q, a);
        end
        `CHK(a, 1'b0)
        host.stop();
    endtask
    task automatic rd(input logic [15:0] ra, input logic [31:0] e,
        input int n);
        logic [7:0] q;
        logic [15:0] v;
        logic a;
        addr(ra);
        host.start();
        host.xfer({XTB_DEV_ADDR, 1'b1}, 1'b1, q, a);
        for (int k = 0; k < n; k++) begin
            host.xfer(8'hFF, 1'b0, v[15:8], a);
            host.xfer(8'hFF, k == n - 1, v[7:0], a);
            `CHK(v, e[31 - 16 * k -: 16])
        end
        host.stop();
    endtask
    task automatic tick();
        sample_tick = 1'b1;
        host.hc(1);
        sample_tick = 1'b0;
        host.hc(2);
    endtask
    task automatic outs(input logic [9:0] h, input logic [5:0] t,
        input logic [5:0] w, input logic [4:0] b, input logic [8:0] c);
        `CHK({hp, tw, wf, boost, center}, {h, t, w, b, c})
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            finish_test();
        end
    end
    initial begin
        logic [5:0] c;
        logic [7:0] q;
        logic a;
        rst = 1'b1;
        sample_tick = 1'b0;
        host.hc(6);
        rst = 1'b0;
        host.hc(4);
        outs(10'h064, 6'h00, 6'h00, 5'h06, 9'h03C);
        rd(XTB_OFS_XOVER, {XTB_RST_XOVER, XTB_RST_TRIM}, 2);
        rd(XTB_OFS_BASS, {XTB_RST_BASS, 16'h0000}, 1);
        wr(XTB_OFS_TRIM, 32'h001C_01FF, 2);
        // Nothing may move before the sample boundary
        outs(10'h064, 6'h00, 6'h00, 5'h06, 9'h03C);
        tick();
        outs(10'h064, 6'h0E, 6'h32, 5'h1F, 9'h140);
        rd(XTB_OFS_TRIM, 32'h001C_01FF, 2);
        wr(XTB_OFS_XOVER, 32'h003C_0000, 1);
        tick();
        outs(10'h28A, 6'h0E, 6'h32, 5'h1F, 9'h140);
        for (int i = 0; i < 5; i++) begin
            c = 6'(7 * i);
            wr(XTB_OFS_TRIM, {2'b00, c, 2'b00, 6'h1C - c, 16'h0}, 1);
            tick();
            `CHK({tw, wf}, {6'h0E - c, c - 6'h0E})
        end
        wr(XTB_OFS_XOVER, 32'h0000_0000, 1);
        wr(XTB_OFS_BASS, 32'h0000_0000, 1);
        tick();
        outs(10'h032, 6'h32, 6'h0E, 5'h00, 9'h014);
        wr(16'h0200, 32'hFFFF_0000, 1);
        rd(16'h0200, 32'h0000_0000, 1);
        // A word cut short after its high byte must not land
        addr(XTB_OFS_BASS);
        host.xfer(8'h01, 1'b1, q, a);
        host.stop();
        rd(XTB_OFS_BASS, 32'h0000_0000, 1);
        host.start();
        host.xfer({XTB_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, q, a);
        host.stop();
        `CHK(a, 1'b1)
        finish_test();
    end
endmodule
